// ==== common/ocg_cfg.svh ====
// Offsets, field positions, reset values and timing counts of the over-current trip block
`ifndef OCG_CFG_SVH
`define OCG_CFG_SVH
`define OCG_ADDR_W 4
`define OCG_OFF_MODE 4'h0
`define OCG_OFF_GAINFLT 4'h1
`define OCG_OFF_REF 4'h2
`define OCG_OFF_AMPTRIM 4'h3
`define OCG_OFF_CMPTRIM 4'h4
`define OCG_MODE_LSB 6
`define OCG_TRIP_BIT 7
`define OCG_GAIN_LSB 3
`define OCG_TRIM_MODE_BIT 7
`define OCG_SENSE_BIT 6
`define OCG_RST_MODE 2'h0
`define OCG_RST_GAIN 3'h0
`define OCG_RST_FLT 3'h0
`define OCG_RST_REF 8'h00
`define OCG_RST_TRIM 5'h00
`define OCG_FLT_DIV 4
`define OCG_UNMAPPED_RD 32'h0000_0000
`endif

// ==== common/ocg_pkg.sv ====
// Types of the over-current trip block
package ocg_pkg;
  typedef enum logic [1:0] {
    OCG_MODE_OFF = 2'b00,
    OCG_MODE_NONINV = 2'b01,
    OCG_MODE_INV = 2'b10,
    OCG_MODE_ZERO = 2'b11
  } ocg_mode_t;
  typedef enum logic [1:0] {
    OCG_BUS_IDLE = 2'b00,
    OCG_BUS_ACK = 2'b01
  } ocg_bus_t;
endpackage : ocg_pkg

// ==== hdl/ocg_trip_ctrl.sv ====
// Over-current trip control: mode, switches, gain, reference, debounce and trim registers
`include "ocg_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module ocg_trip_ctrl #(
  parameter int GAIN_W = 3,
  parameter int FLT_W = 3,
  parameter int REF_W = 8,
  parameter int TRIM_W = 5
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic [`OCG_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic cmp_raw,
  input wire logic amp_sense_raw,
  output ocg_pkg::ocg_mode_t trip_mode_sel,
  output logic [3:0] switch_close,
  output logic analog_enable,
  output logic [GAIN_W-1:0] amp_gain_sel,
  output logic gain_invert,
  output logic unity_buffer,
  output logic [REF_W-1:0] dac_level,
  output logic amp_trim_mode,
  output logic [TRIM_W-1:0] amp_trim_code,
  output logic cmp_trim_mode,
  output logic [TRIM_W-1:0] cmp_trim_code,
  output logic filtered_trip_out,
  output logic pwm_shutdown,
  output logic trip_event
);
  import ocg_pkg::*;

  localparam int CNT_W = 8;

  // Decoded debounce length in filter-clock periods
  function automatic logic [CNT_W-1:0] flt_len(input logic [FLT_W-1:0] code);
    flt_len = CNT_W'(1) << code;
  endfunction : flt_len

  // Switch closures S3..S0 for a mode and gain
  function automatic logic [3:0] sw_map(input ocg_mode_t m, input logic [GAIN_W-1:0] g);
    case (m)
      OCG_MODE_NONINV: sw_map = (g == '0) ? 4'b0001 : 4'b1001;
      OCG_MODE_INV: sw_map = 4'b0110;
      OCG_MODE_ZERO: sw_map = 4'b1010;
      default: sw_map = 4'b1010;
    endcase
  endfunction : sw_map

  // Register file state
  ocg_mode_t mode_ff, nxt_mode;
  logic [GAIN_W-1:0] gain_ff, nxt_gain;
  logic [FLT_W-1:0] flt_ff, nxt_flt;
  logic [REF_W-1:0] ref_ff, nxt_ref;
  logic atm_ff, nxt_atm, ctm_ff, nxt_ctm;
  logic [TRIM_W-1:0] atc_ff, nxt_atc, ctc_ff, nxt_ctc;
  logic [31:0] rdata_ff, nxt_rdata;
  ocg_bus_t bus_ff, nxt_bus;
  logic wr_lane0;

  // Pin synchronisers
  logic [1:0] cmp_sync_ff, amp_sync_ff;
  // Filter state
  logic [1:0] div_ff, nxt_div;
  logic [CNT_W-1:0] cnt_ff, nxt_cnt;
  logic trip_ff, nxt_trip, ev_ff, nxt_ev;
  logic cmp_gated, tick;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      cmp_sync_ff <= 2'b00;
      amp_sync_ff <= 2'b00;
    end else begin
      cmp_sync_ff <= {cmp_sync_ff[0], cmp_raw};
      amp_sync_ff <= {amp_sync_ff[0], amp_sense_raw};
    end
  end

  // One-cycle wait state: every access answers on its second edge;
  // a write lands only at the edge where waitrequest is seen low
  assign wr_lane0 = avs_write && avs_byteenable[0] && (bus_ff == OCG_BUS_ACK);

  always_comb begin
    nxt_mode = mode_ff;
    nxt_gain = gain_ff;
    nxt_flt = flt_ff;
    nxt_ref = ref_ff;
    nxt_atm = atm_ff;
    nxt_ctm = ctm_ff;
    nxt_atc = atc_ff;
    nxt_ctc = ctc_ff;
    nxt_rdata = rdata_ff;
    nxt_bus = OCG_BUS_IDLE;
    if ((avs_read || avs_write) && bus_ff == OCG_BUS_IDLE) begin
      nxt_bus = OCG_BUS_ACK;
    end
    if (wr_lane0) begin
      case (avs_address)
        `OCG_OFF_MODE: nxt_mode = ocg_mode_t'(avs_writedata[`OCG_MODE_LSB +: 2]);
        `OCG_OFF_GAINFLT: begin
          // Bit 7 is status only, a write leaves it alone
          nxt_gain = avs_writedata[`OCG_GAIN_LSB +: GAIN_W];
          nxt_flt = avs_writedata[FLT_W-1:0];
        end
        `OCG_OFF_REF: nxt_ref = avs_writedata[REF_W-1:0];
        `OCG_OFF_AMPTRIM: begin
          nxt_atm = avs_writedata[`OCG_TRIM_MODE_BIT];
          nxt_atc = avs_writedata[TRIM_W-1:0];
          // Setting one trim mode drops the other, never both at once
          if (avs_writedata[`OCG_TRIM_MODE_BIT]) begin
            nxt_ctm = 1'b0;
          end
        end
        `OCG_OFF_CMPTRIM: begin
          nxt_ctm = avs_writedata[`OCG_TRIM_MODE_BIT];
          nxt_ctc = avs_writedata[TRIM_W-1:0];
          if (avs_writedata[`OCG_TRIM_MODE_BIT]) begin
            nxt_atm = 1'b0;
          end
        end
        default: nxt_mode = mode_ff;
      endcase
    end
    if (avs_read && bus_ff == OCG_BUS_IDLE) begin
      case (avs_address)
        `OCG_OFF_MODE: nxt_rdata = {24'h00_0000, mode_ff, 6'h00};
        `OCG_OFF_GAINFLT: nxt_rdata = {24'h00_0000, trip_ff, 1'b0, gain_ff, flt_ff};
        `OCG_OFF_REF: nxt_rdata = {24'h00_0000, ref_ff};
        `OCG_OFF_AMPTRIM: nxt_rdata = {24'h00_0000, atm_ff, amp_sync_ff[1] & atm_ff, 1'b0, atc_ff};
        `OCG_OFF_CMPTRIM: nxt_rdata = {24'h00_0000, ctm_ff, cmp_sync_ff[1] & ctm_ff, 1'b0, ctc_ff};
        default: nxt_rdata = `OCG_UNMAPPED_RD;
      endcase
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      mode_ff <= OCG_MODE_OFF;
      gain_ff <= `OCG_RST_GAIN;
      flt_ff <= `OCG_RST_FLT;
      ref_ff <= `OCG_RST_REF;
      atm_ff <= 1'b0;
      ctm_ff <= 1'b0;
      atc_ff <= `OCG_RST_TRIM;
      ctc_ff <= `OCG_RST_TRIM;
      rdata_ff <= 32'h0000_0000;
      bus_ff <= OCG_BUS_IDLE;
    end else begin
      mode_ff <= nxt_mode;
      gain_ff <= nxt_gain;
      flt_ff <= nxt_flt;
      ref_ff <= nxt_ref;
      atm_ff <= nxt_atm;
      ctm_ff <= nxt_ctm;
      atc_ff <= nxt_atc;
      ctc_ff <= nxt_ctc;
      rdata_ff <= nxt_rdata;
      bus_ff <= nxt_bus;
    end
  end

  // Comparator held low while the function is off
  assign cmp_gated = (mode_ff != OCG_MODE_OFF) && cmp_sync_ff[1];
  assign tick = (div_ff == 2'(`OCG_FLT_DIV - 1));

  always_comb begin
    nxt_div = div_ff + 2'd1;
    nxt_cnt = cnt_ff;
    nxt_trip = trip_ff;
    if (mode_ff == OCG_MODE_OFF) begin
      // Filter powered down
      nxt_div = 2'd0;
      nxt_cnt = '0;
      nxt_trip = 1'b0;
    end else if (flt_ff == '0) begin
      nxt_cnt = '0;
      nxt_trip = cmp_gated;
    end else if (cmp_gated == trip_ff) begin
      // Any bounce back restarts the count
      nxt_cnt = '0;
    end else if (tick) begin
      if (cnt_ff + CNT_W'(1) >= flt_len(flt_ff)) begin
        nxt_trip = cmp_gated;
        nxt_cnt = '0;
      end else begin
        nxt_cnt = cnt_ff + CNT_W'(1);
      end
    end
    nxt_ev = nxt_trip && !trip_ff;
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      div_ff <= 2'd0;
      cnt_ff <= '0;
      trip_ff <= 1'b0;
      ev_ff <= 1'b0;
    end else begin
      div_ff <= nxt_div;
      cnt_ff <= nxt_cnt;
      trip_ff <= nxt_trip;
      ev_ff <= nxt_ev;
    end
  end

  // Outputs straight from flip-flops except avs_waitrequest (bus_ff compare); decode is registered once more
  logic [3:0] sw_ff;
  logic en_ff, inv_ff, unity_ff;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      sw_ff <= 4'b1010;
      en_ff <= 1'b0;
      inv_ff <= 1'b0;
      unity_ff <= 1'b0;
    end else begin
      sw_ff <= sw_map(mode_ff, gain_ff);
      en_ff <= (mode_ff != OCG_MODE_OFF);
      inv_ff <= (mode_ff == OCG_MODE_INV);
      unity_ff <= (mode_ff == OCG_MODE_NONINV) && (gain_ff == '0);
    end
  end

  assign trip_mode_sel = mode_ff;
  assign switch_close = sw_ff;
  assign analog_enable = en_ff;
  assign amp_gain_sel = gain_ff;
  assign gain_invert = inv_ff;
  assign unity_buffer = unity_ff;
  assign dac_level = ref_ff;
  assign amp_trim_mode = atm_ff;
  assign amp_trim_code = atc_ff;
  assign cmp_trim_mode = ctm_ff;
  assign cmp_trim_code = ctc_ff;
  assign filtered_trip_out = trip_ff;
  assign pwm_shutdown = trip_ff;
  assign trip_event = ev_ff;
  assign avs_readdata = rdata_ff;
  assign avs_waitrequest = (bus_ff == OCG_BUS_IDLE);
endmodule : ocg_trip_ctrl
`default_nettype wire

// ==== bench/ocg_trip_ctrl_properties.sv ====
// Port-level checker for the over-current trip block
`timescale 1ns/1ps
`default_nettype none
module ocg_trip_ctrl_props #(
  parameter int GAIN_W = 3
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  input wire ocg_pkg::ocg_mode_t trip_mode_sel,
  input wire logic [3:0] switch_close,
  input wire logic analog_enable,
  input wire logic [GAIN_W-1:0] amp_gain_sel,
  input wire logic filtered_trip_out,
  input wire logic pwm_shutdown,
  input wire logic trip_event
);
  import ocg_pkg::*;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  wire logic req = avs_read || avs_write;
  function automatic logic [3:0] sw_of(ocg_mode_t m, logic [GAIN_W-1:0] g);
    case (m)
      OCG_MODE_NONINV: sw_of = (g == '0) ? 4'h1 : 4'h9;
      OCG_MODE_INV: sw_of = 4'h6;
      default: sw_of = 4'ha;
    endcase
  endfunction : sw_of
  a_switch_map: assert property (switch_close == sw_of($past(trip_mode_sel), $past(amp_gain_sel)))
    else $error("switch pattern wrong");
  a_power_off: assert property (analog_enable == ($past(trip_mode_sel) != OCG_MODE_OFF))
    else $error("analog enable wrong");
  a_off_trip_low: assert property ((trip_mode_sel == OCG_MODE_OFF) [*2] |-> !filtered_trip_out)
    else $error("trip high while off");
  a_pwm_follows: assert property (pwm_shutdown == filtered_trip_out)
    else $error("shutdown differs from trip");
  a_event_pulse: assert property (trip_event == (filtered_trip_out && !$past(filtered_trip_out)))
    else $error("trip event misplaced");
  a_ack_one: assert property (req && avs_waitrequest |=> !avs_waitrequest)
    else $error("access not answered");
  a_ack_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("answer longer than a cycle");
  a_ack_cause: assert property (!avs_waitrequest |-> $past(req))
    else $error("answer without request");
  a_rd_upper: assert property (!avs_waitrequest && avs_read |-> avs_readdata[31:8] == 24'h00_0000)
    else $error("read data upper bits set");
  cover property ($rose(filtered_trip_out));
  cover property (trip_mode_sel == OCG_MODE_ZERO);
  cover property (!avs_waitrequest && avs_write);
endmodule : ocg_trip_ctrl_props
bind ocg_trip_ctrl ocg_trip_ctrl_props #(.GAIN_W(GAIN_W)) i_props (.clock, .resetn, .avs_read, .avs_write,
  .avs_readdata, .avs_waitrequest, .trip_mode_sel, .switch_close, .analog_enable, .amp_gain_sel,
  .filtered_trip_out, .pwm_shutdown, .trip_event);
`default_nettype wire

// ==== bench/ocg_trip_ctrl_bench.sv ====
// Register-level testbench for the over-current trip block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin errors++; $display("ERROR %s exp %h got %h", nm, e, g); end end
module ocg_trip_ctrl_bench;
  import ocg_pkg::*;
  logic clock, resetn, avs_read, avs_write, avs_waitrequest, cmp_raw, amp_sense_raw, cmp_drive, cmp_model;
  logic [3:0] avs_address, avs_byteenable, switch_close;
  logic [31:0] avs_writedata, avs_readdata;
  ocg_mode_t trip_mode_sel;
  logic analog_enable, gain_invert, unity_buffer, amp_trim_mode, cmp_trim_mode, filtered_trip_out, pwm_shutdown, trip_event;
  logic [2:0] amp_gain_sel;
  logic [7:0] dac_level, rd, v1, v2;
  logic [4:0] amp_trim_code, cmp_trim_code;
  logic [3:0] sw_tab [4] = '{4'ha, 4'h9, 4'h6, 4'ha};
  int errors, n_checks;
  ocg_trip_ctrl i_dut (.*);
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  // Stands in for the amplifier: offset crossing at code 9
  always @(posedge clock) amp_sense_raw <= amp_trim_code >= 5'h09;
  // Stands in for the comparator during its trim: crossing at code 20
  assign cmp_raw = cmp_model ? (cmp_trim_code >= 5'h14) : cmp_drive;
  task automatic acc(input logic w, input logic [3:0] a, input logic [7:0] d, input logic [3:0] be);
    int t;
    t = 0;
    avs_address <= a;
    avs_writedata <= {24'h00_0000, d};
    avs_byteenable <= be;
    avs_write <= w;
    avs_read <= !w;
    @(posedge clock);
    while (avs_waitrequest !== 1'b0 && t < 50) begin
      @(posedge clock);
      t++;
    end
    if (t >= 50) errors++;
    rd = avs_readdata[7:0];
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clock);
  endtask : acc
  task automatic sweep(input logic [3:0] a, input logic [7:0] start, input int dir, output logic [7:0] at);
    logic prev;
    at = 8'hff;
    for (int i = 0; i < 32 && at == 8'hff; i++) begin
      acc(1, a, start + 8'(dir * i), 4'h1);
      repeat (3) @(posedge clock);
      acc(0, a, 8'h00, 4'h1);
      if (i > 0 && rd[6] != prev) at = {3'h0, rd[4:0]};
      prev = rd[6];
    end
  endtask : sweep
  task automatic wrap_up;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : wrap_up
  initial begin
    repeat (20000) @(posedge clock);
    errors++;
    wrap_up;
  end
  initial begin
    {resetn, avs_read, avs_write, cmp_drive, cmp_model} = 5'h00;
    {avs_address, avs_byteenable, avs_writedata} = '0;
    repeat (8) @(posedge clock);
    resetn <= 1'b1;
    @(posedge clock);
    for (int i = 0; i < 3; i++) begin
      acc(0, i[3:0], 8'h00, 4'h1);
      `CHK("reset", 8'h00, rd)
    end
    acc(1, 4'h1, 8'h08, 4'h1);
    for (int m = 0; m < 4; m++) begin
      acc(1, 4'h0, {m[1:0], 6'h3f}, 4'h1);
      acc(0, 4'h0, 8'h00, 4'h1);
      `CHK("mode", {m[1:0], 6'h00}, rd)
      `CHK("switch", sw_tab[m], switch_close)
      `CHK("power", m != 0, analog_enable)
      `CHK("invert", m == 2, gain_invert)
    end
    acc(1, 4'h1, 8'hff, 4'h1);
    acc(0, 4'h1, 8'h00, 4'h1);
    `CHK("gainflt", 8'h3f, rd)
    `CHK("gain", 3'h7, amp_gain_sel)
    acc(1, 4'h0, 8'h40, 4'h1);
    acc(1, 4'h1, 8'h00, 4'h1);
    acc(1, 4'h2, 8'ha5, 4'h1);
    acc(1, 4'h2, 8'h5a, 4'h0);
    `CHK("unity", 1'b1, unity_buffer)
    `CHK("sw_unity", 4'h1, switch_close)
    `CHK("dac", 8'ha5, dac_level)
    acc(1, 4'h5, 8'h77, 4'h1);
    acc(0, 4'h5, 8'h00, 4'h1);
    `CHK("unmapped", 8'h00, rd)
    $display("registers done");
    cmp_drive <= 1'b1;
    repeat (4) @(posedge clock);
    `CHK("bypass", 1'b1, filtered_trip_out)
    `CHK("pwm", 1'b1, pwm_shutdown)
    acc(0, 4'h1, 8'h00, 4'h1);
    `CHK("trip_bit", 8'h80, rd)
    acc(1, 4'h1, 8'h03, 4'h1);
    cmp_drive <= 1'b0;
    repeat (28) @(posedge clock);
    `CHK("hold", 1'b1, filtered_trip_out)
    repeat (16) @(posedge clock);
    `CHK("release", 1'b0, filtered_trip_out)
    cmp_drive <= 1'b1;
    repeat (12) @(posedge clock);
    cmp_drive <= 1'b0;
    repeat (8) @(posedge clock);
    `CHK("glitch", 1'b0, filtered_trip_out)
    cmp_drive <= 1'b1;
    acc(1, 4'h1, 8'h00, 4'h1);
    acc(1, 4'h0, 8'h00, 4'h1);
    repeat (6) @(posedge clock);
    `CHK("off_low", 1'b0, filtered_trip_out)
    cmp_drive <= 1'b0;
    $display("filter done");
    acc(1, 4'h0, 8'hc0, 4'h1);
    acc(1, 4'h4, 8'h80, 4'h1);
    acc(1, 4'h3, 8'h80, 4'h1);
    `CHK("excl", 1'b0, cmp_trim_mode)
    sweep(4'h3, 8'h80, 1, v1);
    sweep(4'h3, 8'h9f, -1, v2);
    acc(1, 4'h3, 8'h80 | ((v1 + v2) >> 1), 4'h1);
    repeat (3) @(posedge clock);
    acc(0, 4'h3, 8'h00, 4'h1);
    `CHK("trim", 8'h88, rd)
    `CHK("atc", 5'h08, amp_trim_code)
    cmp_model <= 1'b1;
    acc(1, 4'h4, 8'h80, 4'h1);
    `CHK("excl_a", 1'b0, amp_trim_mode)
    sweep(4'h4, 8'h80, 1, v1);
    sweep(4'h4, 8'h9f, -1, v2);
    acc(1, 4'h4, 8'h80 | ((v1 + v2) >> 1), 4'h1);
    repeat (3) @(posedge clock);
    acc(0, 4'h4, 8'h00, 4'h1);
    `CHK("ctrim", 8'h93, rd)
    `CHK("ctc", 5'h13, cmp_trim_code)
    `CHK("ctm", 1'b1, cmp_trim_mode)
    `CHK("mode_sel", OCG_MODE_ZERO, trip_mode_sel)
    $display("trim done");
    wrap_up;
  end
endmodule : ocg_trip_ctrl_bench
`default_nettype wire
